// ---- src/acsu_consts.svh ----
// Offsets, field positions, reset values and masks of the compare-swap unit.
`ifndef ACSU_CONSTS_SVH
`define ACSU_CONSTS_SVH
// Register byte offsets on the plain register port.
`define ACSU_REG_AW 6
`define ACSU_OFF_CTRL 6'h00
`define ACSU_OFF_STATUS 6'h04
`define ACSU_OFF_COUNT 6'h08
`define ACSU_OFF_PERM0 6'h10
`define ACSU_OFF_PERM7 6'h2C
// Control fields and reset values.
`define ACSU_CTRL_ENABLE 0
`define ACSU_CTRL_CLRCNT 1
`define ACSU_CTRL_RESET 1'h1
`define ACSU_PERM_RESET 32'hFFFF_FFFF
`define ACSU_PERM_WORDS 8
// Status fields.
`define ACSU_ST_EXC_LSB 0
`define ACSU_ST_EXC_MSB 2
`define ACSU_ST_BUSY 3
`define ACSU_ST_EQUAL 4
// Space identifier fields and the range closed to privileged code.
`define ACSU_SPACE_USER_BIT 7
`define ACSU_SPACE_RSV_LO 8'h30
`define ACSU_SPACE_RSV_HI 8'h7F
// Alignment masks for the two operand sizes.
`define ACSU_ALIGN_DW 3'h7
`define ACSU_ALIGN_W 3'h3
`endif

// ---- src/acsu_pkg.sv ----
// Types shared by the compare-swap unit and its helpers.
package acsu_pkg;
	// Exception outcome of one operation.
	typedef enum logic [2:0] {
		ACSU_EXC_NONE = 3'h0,
		ACSU_EXC_ILLEGAL = 3'h1,
		ACSU_EXC_MISALIGN = 3'h2,
		ACSU_EXC_PRIV = 3'h3,
		ACSU_EXC_SPACE = 3'h4,
		ACSU_EXC_LOAD = 3'h5,
		ACSU_EXC_STORE = 3'h6
	} acsu_exc_t;
	// One instruction as handed over by the issue logic.
	typedef struct packed {
		logic op_dword;
		logic imm_sel;
		logic [7:0] enc_bits;
		logic [7:0] imm_space;
		logic [63:0] addr;
		logic [63:0] cmp;
		logic [63:0] dst;
	} acsu_req_t;
	// Result returned to the register and trap logic.
	typedef struct packed {
		logic [63:0] dst_value;
		logic dst_write;
		acsu_exc_t exc;
	} acsu_rsp_t;
	// Command toward the memory system.
	typedef struct packed {
		logic [63:0] addr;
		logic [7:0] space;
		logic dword;
		logic [63:0] wdata;
	} acsu_mem_t;
endpackage : acsu_pkg

// ---- src/acsu_check.sv ----
// Space selection and exception screening for one compare-swap.
`timescale 1ns/1ps
`include "acsu_consts.svh"
module acsu_check
	import acsu_pkg::*;
(
	input wire acsu_req_t req,
	input wire logic [7:0] space_reg,
	input wire logic priv,
	input wire logic [255:0] perm,
	output logic [7:0] space,
	output acsu_exc_t exc
);
	// Screening is one combinational cone; the order below is the priority.
	always_comb
	begin
		space = req.imm_sel ? space_reg : req.imm_space; // R10
		exc = ACSU_EXC_NONE;
		if (req.imm_sel && (req.enc_bits != 8'h00))
			exc = ACSU_EXC_ILLEGAL; // R11
		else if (req.op_dword ? (req.addr[2:0] & `ACSU_ALIGN_DW) != 3'h0
			: (req.addr[2:0] & `ACSU_ALIGN_W) != 3'h0)
			exc = ACSU_EXC_MISALIGN; // R12
		else if (!priv && !space[`ACSU_SPACE_USER_BIT])
			exc = ACSU_EXC_PRIV; // R13
		else if (priv && space >= `ACSU_SPACE_RSV_LO
			&& space <= `ACSU_SPACE_RSV_HI)
			exc = ACSU_EXC_PRIV; // R14
		else if (!perm[space])
			exc = ACSU_EXC_SPACE; // R16
	end
endmodule : acsu_check

// ---- src/acsu_merge.sv ----
// Compare and result forming for both operand sizes.
`timescale 1ns/1ps
module acsu_merge
	import acsu_pkg::*;
(
	input wire logic dword,
	input wire logic [63:0] cmp,
	input wire logic [63:0] dst,
	input wire logic [63:0] mem,
	output logic equal,
	output logic [63:0] store_data,
	output logic [63:0] dst_result
);
	// Word form looks at low halves only and zero-fills the register.
	always_comb
	begin
		if (dword)
		begin
			equal = (cmp == mem); // R1
			store_data = equal ? dst : mem; // R2 R3 R9
			dst_result = mem; // R2 R3
		end
		else
		begin
			equal = (cmp[31:0] == mem[31:0]); // R4
			store_data = {32'h0000_0000, equal ? dst[31:0] : mem[31:0]}; // R5 R9
			dst_result = {32'h0000_0000, mem[31:0]}; // R5 R6
		end
	end
endmodule : acsu_merge

// ---- src/acsu_top.sv ----
// Atomic compare-and-swap execution unit with its register port.
// How it works
// R1 - Doubleword form compares full register with memory.
// R2 - Equal doubleword: swap register and memory.
// R3 - Unequal doubleword: load memory, memory unchanged.
// R4 - Word form compares low 32 bits only.
// R5 - Equal word: swap low halves, upper cleared.
// R6 - Unequal word: load low half, upper cleared.
// R7 - No interrupts recognised between load and store.
// R8 - Memory locks enclosing doubleword during exchange.
// R9 - Always store, old value when unequal.
// R10 - Space from immediate field or space register.
// R11 - Select bit set, bits 12:5 nonzero: illegal.
// R12 - Misaligned address raises alignment exception.
// R13 - Unprivileged with space bit 7 clear: violation.
// R14 - Privileged with space 30..7F: violation.
// R15 - Condition codes never modified.
// R16 - Space outside permitted set: invalid-space exception.
// R17 - Store fault may trap after clean load.
// R18 - Exceptions leave register and memory untouched.
`timescale 1ns/1ps
`include "acsu_consts.svh"
module acsu_top
	import acsu_pkg::*;
#(
	parameter int CNT_W = 32
)
(
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic [`ACSU_REG_AW-1:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	input wire logic REQ_VALID,
	input wire acsu_req_t REQ,
	output logic REQ_READY,
	input wire logic [7:0] SPACE_ID_REG,
	input wire logic PRIVILEGE_STATE_BIT,
	output logic RSP_VALID,
	output acsu_rsp_t RSP,
	output logic HOLD_INTERRUPTS,
	output logic MEM_LOCK,
	output acsu_mem_t MEM_CMD,
	output logic MEM_RD_REQ,
	input wire logic MEM_RD_VALID,
	input wire logic [63:0] MEM_RD_DATA,
	input wire logic MEM_RD_ERR,
	output logic MEM_WR_REQ,
	input wire logic MEM_WR_DONE,
	input wire logic MEM_WR_ERR
);
	// The count register is at most one bus word wide.
	generate
		if (CNT_W < 1 || CNT_W > 32)
		begin : g_bad_cnt
			$error("CNT_W must lie between 1 and 32");
		end
	endgenerate

	// One-hot sequencer states.
	typedef enum logic [5:0] {
		ACSU_IDLE = 6'b000001,
		ACSU_CHECK = 6'b000010,
		ACSU_READ = 6'b000100,
		ACSU_WRITE = 6'b001000,
		ACSU_RESP = 6'b010000,
		ACSU_DONE = 6'b100000
	} acsu_state_t;

	acsu_state_t state; // Current sequencer state.
	acsu_state_t next_state; // State for the next edge.
	acsu_req_t held; // Instruction latched when taken.
	logic [7:0] held_space_reg; // Space register as seen at take.
	logic held_priv; // Privilege bit as seen at take.
	logic [7:0] space; // Selected address space.
	acsu_exc_t chk_exc; // Result of the screening cone.
	logic [63:0] rdata; // Memory value captured from the load.
	logic equal; // Comparison outcome.
	logic [63:0] store_data; // Value to write back.
	logic [63:0] dst_result; // Value for the destination register.
	logic [63:0] merge_mem; // Load data as the compare sees it.
	logic enable; // Software enable for new operations.
	logic [31:0] perm [`ACSU_PERM_WORDS]; // Permitted space bitmap.
	logic [255:0] perm_flat; // Bitmap as one vector.
	acsu_exc_t last_exc; // Outcome of the latest operation.
	logic last_equal; // Compare outcome of the latest operation.
	logic [CNT_W-1:0] done_count; // Operations finished without trap.
	logic take; // A request is taken this cycle.

	// Flatten the bitmap words for the screening logic.
	always_comb
	begin
		for (int i = 0; i < `ACSU_PERM_WORDS; i++)
			perm_flat[i*32 +: 32] = perm[i];
	end

	acsu_check u_check (
		.req(held),
		.space_reg(held_space_reg),
		.priv(held_priv),
		.perm(perm_flat),
		.space(space),
		.exc(chk_exc)
	);

	acsu_merge u_merge (
		.dword(held.op_dword),
		.cmp(held.cmp),
		.dst(held.dst),
		.mem(merge_mem),
		.equal(equal),
		.store_data(store_data),
		.dst_result(dst_result)
	);

	// The store value is formed from the load data of the answer cycle,
	// so the write can start without waiting for the captured copy.
	assign merge_mem = (state == ACSU_READ) ? MEM_RD_DATA : rdata;

	// Handshake outputs follow the state directly.
	assign REQ_READY = (state == ACSU_IDLE) && enable;
	assign take = REQ_VALID && REQ_READY;
	assign MEM_RD_REQ = (state == ACSU_READ);
	assign MEM_WR_REQ = (state == ACSU_WRITE);
	assign MEM_LOCK = (state == ACSU_READ) || (state == ACSU_WRITE); // R8
	// Interrupts stay blocked from the load until the store settles.
	assign HOLD_INTERRUPTS = MEM_LOCK; // R7
	assign RSP_VALID = (state == ACSU_RESP);

	// Sequencer: screen, locked load, store, then answer once.
	always_comb
	begin
		next_state = state;
		case (state)
			ACSU_IDLE:
				if (take)
					next_state = ACSU_CHECK;
			ACSU_CHECK:
				// Traps are decided before memory is touched.
				if (chk_exc != ACSU_EXC_NONE)
					next_state = ACSU_RESP; // R18
				else
					next_state = ACSU_READ;
			ACSU_READ:
				if (MEM_RD_VALID)
					next_state = MEM_RD_ERR ? ACSU_RESP : ACSU_WRITE;
			ACSU_WRITE:
				// A store is issued even when the compare fails.
				if (MEM_WR_DONE)
					next_state = ACSU_RESP; // R9
			ACSU_RESP:
				next_state = ACSU_DONE;
			ACSU_DONE:
				next_state = ACSU_IDLE;
			default:
				next_state = ACSU_IDLE;
		endcase
	end

	// State register.
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
			state <= ACSU_IDLE;
		else
			state <= next_state;
	end

	// The instruction and the live context are frozen at take.
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			held <= '0;
			held_space_reg <= 8'h00;
			held_priv <= 1'b0;
		end
		else if (take)
		begin
			held <= REQ;
			held_space_reg <= SPACE_ID_REG;
			held_priv <= PRIVILEGE_STATE_BIT;
		end
	end

	// Load data is kept for compare and for the register result.
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
			rdata <= 64'h0000_0000_0000_0000;
		else if (state == ACSU_READ && MEM_RD_VALID)
			rdata <= MEM_RD_DATA;
	end

	// Memory command: address and space at screening, data after load.
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
			MEM_CMD <= '0;
		else if (state == ACSU_CHECK)
		begin
			MEM_CMD.addr <= held.addr;
			MEM_CMD.space <= space; // R10
			MEM_CMD.dword <= held.op_dword;
			MEM_CMD.wdata <= 64'h0000_0000_0000_0000;
		end
		else if (state == ACSU_READ && MEM_RD_VALID)
			MEM_CMD.wdata <= store_data; // R2 R3 R5 R9
	end

	// Bitmap word for a register offset; the first word sits at index 4
	// of the address, so flipping that bit puts it at word 0.
	function automatic logic [2:0] perm_word(input logic [5:0] addr);
		return addr[4:2] ^ 3'h4;
	endfunction : perm_word

	// Answer to the trap and register logic; no condition code path exists.
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
			RSP <= '0;
		else if (state == ACSU_CHECK && chk_exc != ACSU_EXC_NONE)
		begin
			RSP.dst_value <= 64'h0000_0000_0000_0000;
			RSP.dst_write <= 1'b0; // R18
			RSP.exc <= chk_exc;
		end
		else if (state == ACSU_READ && MEM_RD_VALID && MEM_RD_ERR)
		begin
			RSP.dst_value <= 64'h0000_0000_0000_0000;
			RSP.dst_write <= 1'b0;
			RSP.exc <= ACSU_EXC_LOAD;
		end
		else if (state == ACSU_WRITE && MEM_WR_DONE)
		begin
			// A store fault traps although the load was clean.
			RSP.dst_value <= MEM_WR_ERR ? 64'h0000_0000_0000_0000
				: dst_result; // R17 R15
			RSP.dst_write <= !MEM_WR_ERR; // R17
			RSP.exc <= MEM_WR_ERR ? ACSU_EXC_STORE : ACSU_EXC_NONE;
		end
	end

	// Status bookkeeping for software.
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			last_exc <= ACSU_EXC_NONE;
			last_equal <= 1'b0;
		end
		else if (state == ACSU_RESP)
		begin
			last_exc <= RSP.exc;
			last_equal <= equal && (RSP.exc == ACSU_EXC_NONE);
		end
	end

	// Finished operations; a clear request loses to a count.
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
			done_count <= '0;
		else if (state == ACSU_RESP && RSP.exc == ACSU_EXC_NONE)
			done_count <= done_count + 1'b1;
		else if (REG_WR && REG_ADDR == `ACSU_OFF_CTRL
			&& REG_WDATA[`ACSU_CTRL_CLRCNT])
			done_count <= '0;
	end

	// Control and bitmap writes from the register port.
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			enable <= `ACSU_CTRL_RESET;
			for (int i = 0; i < `ACSU_PERM_WORDS; i++)
				perm[i] <= `ACSU_PERM_RESET;
		end
		else if (REG_WR)
		begin
			if (REG_ADDR == `ACSU_OFF_CTRL)
				enable <= REG_WDATA[`ACSU_CTRL_ENABLE];
			else if (REG_ADDR >= `ACSU_OFF_PERM0
				&& REG_ADDR <= `ACSU_OFF_PERM7 && REG_ADDR[1:0] == 2'b00)
				perm[perm_word(REG_ADDR)] <= REG_WDATA;
		end
	end

	// Read data stand one cycle after the strobe; unmapped reads are zero.
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
			REG_RDATA <= 32'h0000_0000;
		else if (REG_RD)
		begin
			REG_RDATA <= 32'h0000_0000;
			if (REG_ADDR == `ACSU_OFF_CTRL)
				REG_RDATA[`ACSU_CTRL_ENABLE] <= enable;
			else if (REG_ADDR == `ACSU_OFF_STATUS)
			begin
				REG_RDATA[`ACSU_ST_EXC_MSB:`ACSU_ST_EXC_LSB] <= last_exc;
				REG_RDATA[`ACSU_ST_BUSY] <= (state != ACSU_IDLE);
				REG_RDATA[`ACSU_ST_EQUAL] <= last_equal;
			end
			else if (REG_ADDR == `ACSU_OFF_COUNT)
				REG_RDATA[CNT_W-1:0] <= done_count;
			else if (REG_ADDR >= `ACSU_OFF_PERM0
				&& REG_ADDR <= `ACSU_OFF_PERM7 && REG_ADDR[1:0] == 2'b00)
				REG_RDATA <= perm[perm_word(REG_ADDR)];
		end
	end

	// A clean load leads straight to the store.
	sequence s_load_ok;
		state == ACSU_READ && MEM_RD_VALID && !MEM_RD_ERR;
	endsequence
	sequence s_store_phase;
		MEM_WR_REQ && MEM_LOCK && HOLD_INTERRUPTS;
	endsequence

	load_then_store_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R7
		s_load_ok |=> s_store_phase)
		else $error("store did not follow a clean load under lock");
	lock_span_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R8
		MEM_LOCK && !(MEM_WR_REQ && MEM_WR_DONE)
		&& !(MEM_RD_VALID && MEM_RD_ERR) |=> MEM_LOCK)
		else $error("lock dropped during exchange");
	dword_swap_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R2
		MEM_WR_REQ && held.op_dword && held.cmp == rdata
		|-> MEM_CMD.wdata == held.dst)
		else $error("equal doubleword did not store register");
	keep_old_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R3
		MEM_WR_REQ && held.op_dword && held.cmp != rdata
		|-> MEM_CMD.wdata == rdata)
		else $error("unequal doubleword changed memory");
	word_upper_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R6
		RSP_VALID && !held.op_dword && RSP.dst_write
		|-> RSP.dst_value == {32'h0000_0000, rdata[31:0]})
		else $error("word result not zero-extended memory word");
	trap_no_write_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R18
		state == ACSU_CHECK && chk_exc != ACSU_EXC_NONE
		|=> RSP_VALID && !RSP.dst_write && !MEM_RD_REQ && !MEM_WR_REQ)
		else $error("trapped operation touched register or memory");
	illegal_enc_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R11
		state == ACSU_CHECK && held.imm_sel && held.enc_bits != 8'h00
		|=> RSP.exc == ACSU_EXC_ILLEGAL)
		else $error("nonzero bits 12:5 not refused");
	user_priv_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R13
		state == ACSU_CHECK && !held_priv && !space[7]
		&& chk_exc != ACSU_EXC_ILLEGAL && chk_exc != ACSU_EXC_MISALIGN
		|=> RSP.exc == ACSU_EXC_PRIV)
		else $error("unprivileged access to restricted space allowed");
	store_fault_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // R17
		MEM_WR_REQ && MEM_WR_DONE && MEM_WR_ERR
		|=> RSP_VALID && RSP.exc == ACSU_EXC_STORE && !RSP.dst_write)
		else $error("store fault not reported");
endmodule : acsu_top

// ---- verification/acsu_mem_model.sv ----
// Behavioural memory system that answers locked read-modify-write traffic.
`timescale 1ns/1ps
module acsu_mem_model
	import acsu_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic lock,
	input wire acsu_mem_t cmd,
	input wire logic rd_req,
	input wire logic wr_req,
	input wire logic [3:0] wait_n,
	input wire logic rd_fail,
	input wire logic wr_fail,
	output logic rd_valid,
	output logic [63:0] rd_data,
	output logic rd_err,
	output logic wr_done,
	output logic wr_err,
	output int writes,
	output int faults
);
	// Sixteen doublewords, picked by address bits 6:3.
	logic [63:0] mem [0:15];
	logic [3:0] cnt; // Wait cycles spent on the pending request.
	logic [63:0] rd_addr; // Address of the last read.
	logic [63:0] cur; // Doubleword that the command points at.
	logic [31:0] wd; // Word that the command points at.
	assign cur = mem[cmd.addr[6:3]];
	assign wd = cmd.addr[2] ? cur[63:32] : cur[31:0];
	// A read answer and a write answer each come after wait_n idle cycles; the idle data bus toggles.
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			{rd_valid, rd_err, wr_done, wr_err, cnt} <= '0;
			rd_data <= 64'h5A5A_5A5A_5A5A_5A5A;
			{writes, faults} <= '0;
			rd_addr <= '0;
			for (int i = 0; i < 16; i++)
				mem[i] <= 64'h0;
		end
		else
		begin
			{rd_valid, rd_err, wr_done, wr_err} <= '0;
			rd_data <= ~rd_data;
			if (!(rd_req || wr_req) || rd_valid || wr_done)
				cnt <= 4'h0;
			else if (cnt != wait_n)
				cnt <= cnt + 4'h1;
			else if (rd_req)
			begin
				// Word data sits low; the upper half is junk, so it is not trusted.
				rd_valid <= 1'b1;
				rd_err <= rd_fail;
				rd_addr <= cmd.addr;
				rd_data <= cmd.dword ? cur : {~wd, wd};
				faults <= faults + int'(!lock);
			end
			else
			begin
				// The write must stay locked to the address just read.
				wr_done <= 1'b1;
				wr_err <= wr_fail;
				writes <= writes + 1;
				faults <= faults + int'(!lock || cmd.addr !== rd_addr
					|| (!cmd.dword && cmd.wdata[63:32] !== 32'h0));
				if (!wr_fail && cmd.dword)
					mem[cmd.addr[6:3]] <= cmd.wdata;
				else if (!wr_fail && cmd.addr[2])
					mem[cmd.addr[6:3]][63:32] <= cmd.wdata[31:0];
				else if (!wr_fail)
					mem[cmd.addr[6:3]][31:0] <= cmd.wdata[31:0];
			end
		end
	end
endmodule : acsu_mem_model

// ---- verification/acsu_top_tb_top.sv ----
// Self-checking bench for the compare-swap unit with its memory partner.
`timescale 1ns/1ps
`include "acsu_consts.svh"
`define CHK(g, e) \
	begin \
		comparisons++; \
		if ((g) !== (e)) \
		begin \
			err_count++; \
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
		end \
	end
module acsu_top_tb_top
	import acsu_pkg::*;
;
	logic CLK_SYS = 1'b0;
	logic RESET = 1'b1;
	logic [5:0] REG_ADDR = '0;
	logic [31:0] REG_WDATA = '0;
	logic REG_WR = 1'b0;
	logic REG_RD = 1'b0;
	logic [31:0] REG_RDATA;
	logic REQ_VALID = 1'b0;
	acsu_req_t REQ = '0;
	logic [7:0] SPACE_ID_REG = '0;
	logic PRIVILEGE_STATE_BIT = 1'b0;
	logic REQ_READY, RSP_VALID, HOLD_INTERRUPTS, MEM_LOCK;
	acsu_rsp_t RSP;
	acsu_mem_t MEM_CMD;
	logic MEM_RD_REQ, MEM_RD_VALID, MEM_RD_ERR;
	logic MEM_WR_REQ, MEM_WR_DONE, MEM_WR_ERR;
	logic [63:0] MEM_RD_DATA;
	logic [3:0] wait_n = 4'h0; // Memory answer delay in cycles.
	logic rd_fail = 1'b0; // Makes the next load fail.
	logic wr_fail = 1'b0; // Makes the next store fail.
	int writes, faults;
	int err_count = 0;
	int comparisons = 0;
	int leaks = 0; // Memory requests seen without interrupts held.
	logic [31:0] rd;

	acsu_top #(.CNT_W(32)) u_acsu_top (
		.CLK_SYS(CLK_SYS), .RESET(RESET), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_RDATA(REG_RDATA), .REQ_VALID(REQ_VALID), .REQ(REQ),
		.REQ_READY(REQ_READY), .SPACE_ID_REG(SPACE_ID_REG),
		.PRIVILEGE_STATE_BIT(PRIVILEGE_STATE_BIT), .RSP_VALID(RSP_VALID),
		.RSP(RSP), .HOLD_INTERRUPTS(HOLD_INTERRUPTS), .MEM_LOCK(MEM_LOCK),
		.MEM_CMD(MEM_CMD), .MEM_RD_REQ(MEM_RD_REQ),
		.MEM_RD_VALID(MEM_RD_VALID), .MEM_RD_DATA(MEM_RD_DATA),
		.MEM_RD_ERR(MEM_RD_ERR), .MEM_WR_REQ(MEM_WR_REQ),
		.MEM_WR_DONE(MEM_WR_DONE), .MEM_WR_ERR(MEM_WR_ERR)
	);
	acsu_mem_model u_acsu_mem_model (
		.clk(CLK_SYS), .rst(RESET), .lock(MEM_LOCK), .cmd(MEM_CMD),
		.rd_req(MEM_RD_REQ), .wr_req(MEM_WR_REQ), .wait_n(wait_n),
		.rd_fail(rd_fail), .wr_fail(wr_fail), .rd_valid(MEM_RD_VALID),
		.rd_data(MEM_RD_DATA), .rd_err(MEM_RD_ERR), .wr_done(MEM_WR_DONE),
		.wr_err(MEM_WR_ERR), .writes(writes), .faults(faults)
	);

	// The clock runs at 250 MHz.
	always #2 CLK_SYS = ~CLK_SYS;

	// Interrupts must stay held while any memory request is pending.
	always @(negedge CLK_SYS)
		if ((MEM_RD_REQ || MEM_WR_REQ) && HOLD_INTERRUPTS !== 1'b1)
			leaks++;

	// Prints the verdict and ends the run.
	task automatic stop_test();
		if (err_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test

	// A wait that used up its bound counts as a mismatch and ends the run.
	task automatic tmo(input int n);
		if (n < 50)
			return;
		err_count++;
		stop_test();
	endtask : tmo

	task automatic reg_wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge CLK_SYS);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLK_SYS);
		REG_WR <= 1'b0;
	endtask : reg_wr

	// Read data stand from the cycle after the strobe until the next read.
	task automatic reg_rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge CLK_SYS);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLK_SYS);
		REG_RD <= 1'b0;
		@(negedge CLK_SYS);
		d = REG_RDATA;
	endtask : reg_rd

	// Flags f are {doubleword, immediate select, privilege}.
	task automatic run_op(input logic [2:0] f, input logic [7:0] enc, sp,
		sreg, input logic [63:0] a, c, d);
		int n;
		@(posedge CLK_SYS);
		REQ <= '{f[2], f[1], enc, sp, a, c, d};
		SPACE_ID_REG <= sreg;
		PRIVILEGE_STATE_BIT <= f[0];
		REQ_VALID <= 1'b1;
		@(negedge CLK_SYS);
		for (n = 0; n < 50 && REQ_READY !== 1'b1; n++)
			@(negedge CLK_SYS);
		tmo(n);
		@(posedge CLK_SYS);
		REQ_VALID <= 1'b0;
		@(negedge CLK_SYS);
		for (n = 0; n < 50 && RSP_VALID !== 1'b1; n++)
			@(negedge CLK_SYS);
		tmo(n);
	endtask : run_op

	// Runs one unequal operation and judges its outcome code.
	task automatic xc(input logic [2:0] f, input logic [7:0] enc, sp, sreg,
		a, input acsu_exc_t e);
		int w;
		w = writes;
		run_op(f, enc, sp, sreg, {56'h0, a}, 64'h1, 64'h2);
		`CHK(RSP.exc, e)
		`CHK(RSP.dst_write, e == ACSU_EXC_NONE)
		`CHK(writes - w, int'(e == ACSU_EXC_NONE))
	endtask : xc

	task automatic t_regs();
		reg_rd(`ACSU_OFF_CTRL, rd);
		`CHK(rd, 32'h0000_0001)
		reg_rd(`ACSU_OFF_PERM7, rd);
		`CHK(rd, `ACSU_PERM_RESET)
		reg_rd(6'h3C, rd);
		`CHK(rd, 32'h0000_0000)
		reg_wr(`ACSU_OFF_CTRL, 32'h0000_0000);
		@(negedge CLK_SYS);
		`CHK(REQ_READY, 1'b0)
		reg_wr(`ACSU_OFF_CTRL, 32'h0000_0001);
	endtask : t_regs

	task automatic t_dword();
		int w;
		u_acsu_mem_model.mem[2] = 64'h1122_3344_5566_7788;
		run_op(3'b100, 8'h00, 8'h80, 8'h00, 64'h10, 64'h1122_3344_5566_7788,
			64'hAAAA_BBBB_CCCC_DDDD);
		`CHK(RSP.dst_value, 64'h1122_3344_5566_7788)
		`CHK(u_acsu_mem_model.mem[2], 64'hAAAA_BBBB_CCCC_DDDD)
		`CHK(MEM_CMD.space, 8'h80)
		// The read lands in the closing cycle, so busy still shows.
		reg_rd(`ACSU_OFF_STATUS, rd);
		`CHK(rd, 32'h0000_0018)
		// Only bit 63 differs, and the memory answers slowly.
		wait_n = 4'h3;
		w = writes;
		run_op(3'b100, 8'h00, 8'h80, 8'h00, 64'h10, 64'h2AAA_BBBB_CCCC_DDDD,
			64'h0);
		`CHK(RSP.dst_value, 64'hAAAA_BBBB_CCCC_DDDD)
		`CHK(u_acsu_mem_model.mem[2], 64'hAAAA_BBBB_CCCC_DDDD)
		`CHK(writes - w, 1)
		wait_n = 4'h0;
	endtask : t_dword

	task automatic t_word();
		u_acsu_mem_model.mem[3] = 64'h0BAD_F00D_1234_5678;
		run_op(3'b000, 8'h00, 8'h80, 8'h00, 64'h1C, 64'hFFFF_FFFF_0BAD_F00D,
			64'h9999_9999_CAFE_BEEF);
		`CHK(RSP.dst_value, 64'h0000_0000_0BAD_F00D)
		`CHK(u_acsu_mem_model.mem[3], 64'hCAFE_BEEF_1234_5678)
		run_op(3'b000, 8'h00, 8'h80, 8'h00, 64'h1C, 64'h0BAD_F00D,
			64'h7777_7777_0000_0001);
		`CHK(RSP.dst_value, 64'h0000_0000_CAFE_BEEF)
		`CHK(u_acsu_mem_model.mem[3], 64'hCAFE_BEEF_1234_5678)
	endtask : t_word

	task automatic t_exc();
		xc(3'b110, 8'h01, 8'h80, 8'h80, 8'h10, ACSU_EXC_ILLEGAL);
		xc(3'b110, 8'h80, 8'h80, 8'h80, 8'h14, ACSU_EXC_ILLEGAL);
		xc(3'b100, 8'hFF, 8'h80, 8'h00, 8'h10, ACSU_EXC_NONE);
		xc(3'b100, 8'h00, 8'h80, 8'h80, 8'h14, ACSU_EXC_MISALIGN);
		xc(3'b000, 8'h00, 8'h80, 8'h80, 8'h12, ACSU_EXC_MISALIGN);
		xc(3'b000, 8'h00, 8'h80, 8'h80, 8'h14, ACSU_EXC_NONE);
		xc(3'b100, 8'h00, 8'h7F, 8'h80, 8'h10, ACSU_EXC_PRIV);
		xc(3'b110, 8'h00, 8'h80, 8'h7F, 8'h10, ACSU_EXC_PRIV);
		xc(3'b110, 8'h00, 8'h7F, 8'h81, 8'h10, ACSU_EXC_NONE);
		`CHK(MEM_CMD.space, 8'h81)
		xc(3'b101, 8'h00, 8'h30, 8'h00, 8'h10, ACSU_EXC_PRIV);
		xc(3'b101, 8'h00, 8'h7F, 8'h00, 8'h10, ACSU_EXC_PRIV);
		xc(3'b101, 8'h00, 8'h2F, 8'h00, 8'h10, ACSU_EXC_NONE);
		xc(3'b101, 8'h00, 8'h80, 8'h00, 8'h10, ACSU_EXC_NONE);
	endtask : t_exc

	// Space 0x80 sits in bit 0 of the fifth permission word.
	task automatic t_perm();
		reg_wr(6'h20, 32'hFFFF_FFFE);
		xc(3'b100, 8'h00, 8'h80, 8'h00, 8'h10, ACSU_EXC_SPACE);
		xc(3'b100, 8'h00, 8'h81, 8'h00, 8'h10, ACSU_EXC_NONE);
		reg_wr(6'h20, `ACSU_PERM_RESET);
	endtask : t_perm

	task automatic t_fault();
		int w;
		rd_fail = 1'b1;
		xc(3'b100, 8'h00, 8'h80, 8'h00, 8'h10, ACSU_EXC_LOAD);
		rd_fail = 1'b0;
		wr_fail = 1'b1;
		w = writes;
		run_op(3'b100, 8'h00, 8'h80, 8'h00, 64'h10, 64'hAAAA_BBBB_CCCC_DDDD,
			64'h5);
		`CHK(RSP.exc, ACSU_EXC_STORE)
		`CHK(RSP.dst_write, 1'b0)
		`CHK(writes - w, 1)
		`CHK(u_acsu_mem_model.mem[2], 64'hAAAA_BBBB_CCCC_DDDD)
		wr_fail = 1'b0;
	endtask : t_fault

	// Only operations that finish without a trap are counted.
	task automatic t_count();
		reg_wr(`ACSU_OFF_CTRL, 32'h0000_0003);
		xc(3'b100, 8'h00, 8'h80, 8'h00, 8'h10, ACSU_EXC_NONE);
		xc(3'b100, 8'h00, 8'h80, 8'h00, 8'h11, ACSU_EXC_MISALIGN);
		reg_rd(`ACSU_OFF_COUNT, rd);
		`CHK(rd, 32'h0000_0001)
		reg_rd(`ACSU_OFF_STATUS, rd);
		`CHK(rd[2:0], 3'h2)
	endtask : t_count

	initial
	begin
		repeat (8) @(posedge CLK_SYS);
		RESET <= 1'b0;
		t_regs();
		t_dword();
		t_word();
		t_exc();
		t_perm();
		t_fault();
		t_count();
		`CHK(faults, 0)
		`CHK(leaks, 0)
		stop_test();
	end
endmodule : acsu_top_tb_top
